// File: mc_pkg.sv
// Constants, encodings and reset values shared by the maintenance channel interface.
// Assumes a single 200 MHz clock and an I/O channel bus that presents 12-bit words.
package mc_pkg;
	localparam logic [4:0]  MC_CHANNEL   = 5'h0f;   // Channel 17 octal
	localparam int          MC_NUM_ELEM  = 7;       // Elements on the selector
	localparam int          FN_TYPE_LSB  = 0;       // Function word field positions
	localparam int          FN_OP_LSB    = 4;
	localparam int          FN_CONN_LSB  = 8;
	localparam logic [3:0]  CONN_IO_UNIT = 4'h0;    // IO unit is element 0
	localparam logic [3:0]  OP_HALT      = 4'h0;
	localparam logic [3:0]  OP_START     = 4'h1;
	localparam logic [3:0]  OP_LED_CLR   = 4'h3;
	localparam logic [3:0]  OP_READ      = 4'h4;
	localparam logic [3:0]  OP_WRITE     = 4'h5;
	localparam logic [3:0]  OP_MCLR      = 4'h6;
	localparam logic [3:0]  OP_CLR_ERR   = 4'h7;
	localparam logic [3:0]  OP_ECHO      = 4'h8;
	localparam logic [3:0]  OP_SUMMARY   = 4'hc;
	localparam logic [3:0]  TYPE_CP_REG  = 4'h0;    // Central processor register access
	localparam logic [3:0]  TYPE_CM_REG  = 4'ha;    // Central memory register access
	localparam logic [7:0]  ADR_SUMMARY  = 8'h00;   // IO unit register addresses
	localparam logic [7:0]  ADR_ELEM_ID  = 8'h10;
	localparam logic [7:0]  ADR_OPTIONS  = 8'h12;
	localparam logic [7:0]  ADR_FMASK    = 8'h18;
	localparam logic [7:0]  ADR_STATUS   = 8'h40;
	localparam logic [7:0]  ADR_FAULT1   = 8'h80;
	localparam logic [7:0]  ADR_FAULT2   = 8'h81;
	localparam logic [7:0]  ADR_TEST     = 8'ha0;
	localparam logic [63:0] RST_REG64    = 64'h0;   // Writable registers after reset
	localparam logic [63:0] ELEM_ID_VAL  = 64'h0000_0000_0000_0a5c; // Arbitrary value
	localparam logic [63:0] OPTIONS_VAL  = 64'h0000_0000_0000_0001; // Arbitrary value
	typedef enum logic [2:0] {
		MC_IDLE = 3'b000,   // Waiting for a function word
		MC_CW1  = 3'b001,   // Expecting first control word
		MC_CW2  = 3'b010,   // Expecting second control word
		MC_DATA = 3'b011,   // Register data transfer
		MC_ECHO = 3'b100,   // Echo readback
		MC_SUM  = 3'b101    // Status summary readback
	} mc_state_e;
endpackage

// File: mc_sync.sv
// Two-flop synchroniser for levels arriving from other units.
// Assumes inputs are quasi-static presence levels.
`timescale 1ns/1ps
`default_nettype none
module mc_sync #(
	parameter int W = 6                 // Number of synchronised bits
) (
	input  wire logic         clk,      // System clock
	input  wire logic         rst,      // Asynchronous reset, active high
	input  wire logic [W-1:0] d,        // Asynchronous levels
	output logic      [W-1:0] q         // Synchronised levels
);
	typedef struct packed {
		logic [W-1:0] s1;   // First stage, read only by second
		logic [W-1:0] s2;   // Second stage
	} mcs_s;
	mcs_s st, next_st;
	// Shift the levels through two stages
	always_comb begin
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end
	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign q = st.s2;
endmodule
`default_nettype wire

// File: mc_iou_regs.sv
// Maintenance register file of the IO unit, element 0 on the selector.
// Assumes byte writes and reads addressed by register address and byte index.
`timescale 1ns/1ps
`default_nettype none
module mc_iou_regs
	import mc_pkg::*;
(
	input  wire logic       clk,        // System clock
	input  wire logic       rst,        // Asynchronous reset, active high
	input  wire logic       wr,         // Byte write strobe
	input  wire logic [7:0] addr,       // Register address
	input  wire logic [2:0] bytei,      // Byte index, 0 is leftmost
	input  wire logic [7:0] wdata,      // Write byte
	input  wire logic       clr_fault,  // Clear fault status registers
	input  wire logic       mclr,       // Master clear
	input  wire logic [1:0] fault_evt,  // Fault events for fault status 1 and 2
	input  wire logic       led,        // Board error LED state
	output logic      [7:0] rdata,      // Read byte
	output logic      [7:0] summary     // Status summary byte
);
	typedef struct packed {
		logic [63:0] fmask;     // Fault status mask
		logic [63:0] fault1;    // Fault status 1
		logic [63:0] fault2;    // Fault status 2
		logic [63:0] test;      // Test mode
	} mci_s;
	mci_s st, next_st;
	logic [63:0] rd_word;       // Addressed register as a word
	logic        impl;          // Address holds a register
	// Byte n of a word, byte 0 being the leftmost byte
	function automatic logic [7:0] pick(input logic [63:0] v, input logic [2:0] n);
		pick = v[8*(7-n) +: 8];
	endfunction
	// Replace byte n of a word
	function automatic logic [63:0] put(input logic [63:0] v, input logic [2:0] n,
		input logic [7:0] b);
		logic [63:0] r;
		r = v;
		r[8*(7-n) +: 8] = b;
		put = r;
	endfunction
	assign summary = {4'h0, |st.test, led, |st.fault2, |st.fault1};
	// Read decode; narrow values sit right-justified with zero fill, except ADR_SUMMARY, which repeats the summary in all eight bytes
	always_comb begin
		impl = 1'b1;
		if (addr == ADR_SUMMARY) begin
			rd_word = {8{summary}};
		end else if (addr == ADR_ELEM_ID) begin
			rd_word = ELEM_ID_VAL;
		end else if (addr == ADR_OPTIONS) begin
			rd_word = OPTIONS_VAL;
		end else if (addr == ADR_FMASK) begin
			rd_word = st.fmask;
		end else if (addr == ADR_STATUS) begin
			rd_word = {56'h0, summary};
		end else if (addr == ADR_FAULT1) begin
			rd_word = st.fault1;
		end else if (addr == ADR_FAULT2) begin
			rd_word = st.fault2;
		end else if (addr == ADR_TEST) begin
			rd_word = st.test;
		end else begin
			impl = 1'b0;
			rd_word = 64'h0;
		end
		rdata = pick(rd_word, bytei);
	end
	// Writes reach only the writable registers; fault events win over clears
	always_comb begin
		next_st = st;
		if (wr) begin
			if (addr == ADR_FMASK) begin
				next_st.fmask = put(st.fmask, bytei, wdata);
			end else if (addr == ADR_FAULT1) begin
				next_st.fault1 = put(st.fault1, bytei, wdata);
			end else if (addr == ADR_FAULT2) begin
				next_st.fault2 = put(st.fault2, bytei, wdata);
			end else if (addr == ADR_TEST) begin
				next_st.test = put(st.test, bytei, wdata);
			end
		end
		if (mclr) begin
			next_st = '{RST_REG64, RST_REG64, RST_REG64, RST_REG64};
		end else if (clr_fault) begin
			next_st.fault1 = RST_REG64;
			next_st.fault2 = RST_REG64;
		end
		next_st.fault1[0] = next_st.fault1[0] | fault_evt[0];
		next_st.fault2[0] = next_st.fault2[0] | fault_evt[1];
	end
	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '{RST_REG64, RST_REG64, RST_REG64, RST_REG64};
		end else begin
			st <= next_st;
		end
	end
	a_ro_write: assert property (@(posedge clk) disable iff (rst)
		(wr && !mclr && !clr_fault && fault_evt == 2'b00 && addr != ADR_FMASK &&
		addr != ADR_FAULT1 && addr != ADR_FAULT2 && addr != ADR_TEST) |=> $stable(st))
		else $error("write changed a read-only or missing register");
	a_missing_zero: assert property (@(posedge clk) disable iff (rst)
		!impl |-> rdata == 8'h00)
		else $error("missing register read not zero");
endmodule
`default_nettype wire

// File: mc_chan.sv
// Maintenance channel interface of the IO unit: function and control word decode,
// the radial element selector, and byte transfers to the connected element.
// Assumes channel strobes come from logic on clk, one strobe per cycle at most,
// and each external element answers link_rdata combinationally on clk.
`timescale 1ns/1ps
`default_nettype none
module mc_chan
	import mc_pkg::*;
#(
	parameter int NEL = MC_NUM_ELEM                     // Elements incl. IO unit
) (
	input  wire logic               clk,                // System clock
	input  wire logic               rst,                // Asynchronous reset, high
	input  wire logic [4:0]         ch_num,             // Channel addressed by the bus
	input  wire logic               fn_strobe,          // Function word present
	input  wire logic               out_strobe,         // Output word present
	input  wire logic               in_strobe,          // Input word requested
	input  wire logic [11:0]        ch_wdata,           // Word from processor
	output logic      [11:0]        ch_rdata,           // Word to processor
	output logic                    ch_rvalid,          // Input word valid pulse
	output logic                    err_flag,           // Error flag level
	output logic                    unconnected,        // Channel free for transfers
	output logic      [NEL-1:1]     link_sel,           // Radial element selects
	output logic                    link_func,          // Function pulse to element
	output logic      [3:0]         link_opcode,        // Opcode to element
	output logic      [3:0]         link_type,          // Type to element
	output logic      [7:0]         link_addr,          // Internal register address
	output logic      [2:0]         link_byte,          // Current byte index
	output logic                    link_wr,            // Byte write pulse
	output logic      [7:0]         link_wdata,         // Byte write data
	input  wire logic [NEL-1:1][7:0] link_rdata,        // Read byte from each element
	input  wire logic [NEL-1:1]     link_present,       // Element powered and cabled
	input  wire logic [1:0]         fault_evt,          // IO unit fault events
	input  wire logic               board_err_evt,      // Board error detected
	output logic                    board_led           // Board error LED
);
	typedef struct packed {
		mc_state_e      st;         // Transfer sequence state
		logic [2:0]     conn;       // Connected element number
		logic           unconn;     // No element connected
		logic           err;        // Error flag
		logic [3:0]     op;         // Latched opcode
		logic [3:0]     typ;        // Latched type
		logic [7:0]     addr;       // Internal register address
		logic [2:0]     bytei;      // Byte index
		logic [7:0]     echo;       // Address holding register
		logic [11:0]    rdata;      // Returned word
		logic           rvalid;     // Returned word pulse
		logic [NEL-1:1] sel;        // Element selects
		logic           func;       // Function pulse
		logic           wr;         // Write pulse
		logic [7:0]     wdata;      // Write byte
		logic           led;        // Board error LED
		logic           mclr;       // IO unit master clear pulse
		logic           clrf;       // IO unit fault clear pulse
	} mcc_s;
	mcc_s st, next_st;

	logic [NEL-1:1] present_s;      // Synchronised presence levels
	logic           here;           // Our channel is addressed
	logic           fn;             // Function word for us
	logic           ow;             // Output word for us
	logic           iw;             // Input request for us
	logic [3:0]     w_conn;         // Decoded connect field
	logic [3:0]     w_op;           // Decoded opcode field
	logic [3:0]     w_type;         // Decoded type field
	logic           ext_ok;         // Connected external element is present
	logic [7:0]     src_byte;       // Byte from the connected element
	logic           iou_wr;         // Byte write into IO unit registers
	logic [7:0]     iou_rdata;      // Byte read from IO unit registers
	logic [7:0]     iou_sum;        // IO unit status summary

	// Presence levels come from other units, so synchronise them first
	mc_sync #(
		.W (NEL-1)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   (link_present),
		.q   (present_s)
	);

	// IO unit registers sit on element 0, wired inside the selector
	mc_iou_regs u_iou (
		.clk       (clk),
		.rst       (rst),
		.wr        (iou_wr),
		.addr      (st.addr),
		.bytei     (st.bytei),
		.wdata     (ch_wdata[7:0]),
		.clr_fault (st.clrf),
		.mclr      (st.mclr),
		.fault_evt (fault_evt),
		.led       (st.led),
		.rdata     (iou_rdata),
		.summary   (iou_sum)
	);

	// Channel qualification
	assign here = (ch_num == MC_CHANNEL);
	assign fn = here && fn_strobe;
	assign ow = here && out_strobe;
	assign iw = here && in_strobe;

	// Function word fields
	assign w_conn = ch_wdata[FN_CONN_LSB +: 4];
	assign w_op   = ch_wdata[FN_OP_LSB +: 4];
	assign w_type = ch_wdata[FN_TYPE_LSB +: 4];

	// One select per element, so an absent element only affects itself
	always_comb begin
		ext_ok = 1'b0;
		src_byte = iou_rdata;
		for (int i = 1; i < NEL; i++) begin
			if (st.sel[i]) begin
				ext_ok = present_s[i];
				src_byte = present_s[i] ? link_rdata[i] : 8'h00;
			end
		end
	end

	// Register write into the IO unit only while it is connected and writing
	assign iou_wr = ow && !st.unconn && st.conn == 3'd0 && st.st == MC_DATA &&
		st.op == OP_WRITE;

	// Sequence control
	always_comb begin
		next_st = st;
		next_st.rvalid = 1'b0;
		next_st.func = 1'b0;
		next_st.wr = 1'b0;
		next_st.mclr = 1'b0;
		next_st.clrf = 1'b0;
		if (fn) begin
			// New function word clears the error flag
			next_st.err = 1'b0;
			next_st.op = w_op;
			next_st.typ = w_type;
			next_st.st = MC_IDLE;
			if (w_conn[3] || int'(w_conn) >= NEL) begin
				// Codes 7 (NEL) to 17 octal free the channel
				next_st.unconn = 1'b1;
				next_st.sel = '0;
			end else begin
				next_st.unconn = 1'b0;
				next_st.conn = w_conn[2:0];
				next_st.sel = '0;
				for (int i = 1; i < NEL; i++) begin
					next_st.sel[i] = (w_conn[2:0] == 3'(i));
				end
				if (w_op == OP_READ || w_op == OP_WRITE || w_op == OP_ECHO) begin
					// Control words follow
					next_st.st = MC_CW1;
					// IO unit starts at the type byte, others at byte 0
					next_st.bytei = (w_conn == CONN_IO_UNIT) ? w_type[2:0] : 3'd0;
				end else if (w_conn == CONN_IO_UNIT) begin
					// Operations handled inside the IO unit
					if (w_op == OP_SUMMARY) begin
						next_st.st = MC_SUM;
					end else if (w_op == OP_MCLR) begin
						next_st.mclr = 1'b1;
					end else if (w_op == OP_CLR_ERR) begin
						next_st.clrf = 1'b1;
					end else if (w_op == OP_LED_CLR) begin
						next_st.led = 1'b0;
					end
				end else begin
					// Halt, start, clears and LED clear go to the element
					next_st.func = 1'b1;
				end
			end
		end else if (ow) begin
			if (st.unconn) begin
				next_st.err = 1'b0; // Channel lent to processor traffic
			end else if (st.conn != 3'd0 && !ext_ok) begin
				next_st.err = 1'b1;
			end else begin
				case (st.st)
					MC_CW1: begin
						// First control word is dropped
						next_st.st = MC_CW2;
					end
					MC_CW2: begin
						next_st.addr = ch_wdata[7:0];
						if (st.op == OP_ECHO) begin
							next_st.echo = ch_wdata[7:0];
							next_st.st = MC_ECHO;
						end else begin
							next_st.st = MC_DATA;
							if (st.conn == 3'd0 && (ch_wdata[7:0] == ADR_ELEM_ID ||
								ch_wdata[7:0] == ADR_OPTIONS)) begin
								next_st.bytei = 3'd0;
							end
							if (st.conn != 3'd0) begin
								next_st.func = 1'b1; // Element gets opcode and address
							end
						end
					end
					MC_DATA: begin
						if (st.op == OP_WRITE) begin
							next_st.wr = (st.conn != 3'd0);
							next_st.wdata = ch_wdata[7:0];
							next_st.bytei = st.bytei + 3'd1;
						end else begin
							next_st.err = 1'b1;
						end
					end
					default: begin
						next_st.err = 1'b1;
					end
				endcase
			end
		end else if (iw) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = 12'h000;
			if (st.unconn) begin
				next_st.err = 1'b0;
			end else begin
				case (st.st)
					MC_DATA: begin
						if (st.op == OP_READ && (st.conn == 3'd0 || ext_ok)) begin
							next_st.rdata = {4'h0, src_byte};
							next_st.bytei = st.bytei + 3'd1;
						end else begin
							next_st.err = 1'b1;
						end
					end
					MC_ECHO: begin
						next_st.rdata = {4'h0, st.echo};
					end
					MC_SUM: begin
						next_st.rdata = {4'h0, iou_sum};
					end
					default: begin
						next_st.err = 1'b1;
					end
				endcase
			end
		end
		// A board error wins over a same-cycle LED clear
		if (board_err_evt) begin
			next_st.led = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '{MC_IDLE, 3'd0, 1'b1, 1'b0, 4'h0, 4'h0, 8'h00, 3'd0, 8'h00,
				12'h000, 1'b0, '0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign ch_rdata    = st.rdata;
	assign ch_rvalid   = st.rvalid;
	assign err_flag    = st.err;
	assign unconnected = st.unconn;
	assign link_sel    = st.sel;
	assign link_func   = st.func;
	assign link_opcode = st.op;
	assign link_type   = st.typ;
	assign link_addr   = st.addr;
	assign link_byte   = st.bytei;
	assign link_wr     = st.wr;
	assign link_wdata  = st.wdata;
	assign board_led   = st.led;

	a_ignore_other: assert property (@(posedge clk) disable iff (rst)
		(ch_num != MC_CHANNEL && !board_err_evt) |=> $stable(st.st) && !ch_rvalid)
		else $error("word on another channel was taken");
	a_sel_single: assert property (@(posedge clk) disable iff (rst)
		$onehot0(link_sel))
		else $error("more than one element selected");
	a_sel_hold: assert property (@(posedge clk) disable iff (rst)
		!fn |=> $stable(link_sel) && $stable(unconnected))
		else $error("connection changed without a function word");
	a_free_codes: assert property (@(posedge clk) disable iff (rst)
		(fn && w_conn[3]) |=> unconnected && link_sel == '0)
		else $error("connect code 10-17 octal did not free the channel");
	a_halt_fwd: assert property (@(posedge clk) disable iff (rst)
		(fn && w_conn != 4'h0 && int'(w_conn) < NEL && w_op == OP_HALT)
		|=> link_func && link_opcode == OP_HALT ##1 (!link_func || $past(fn || ow)))
		else $error("halt not sent as one pulse to element");
	a_led_clear: assert property (@(posedge clk) disable iff (rst)
		(fn && w_conn == CONN_IO_UNIT && w_op == OP_LED_CLR && !board_err_evt)
		|=> !board_led && !st.mclr && $stable(st.conn))
		else $error("LED clear wrong");
	a_first_drop: assert property (@(posedge clk) disable iff (rst)
		(ow && !fn && !st.unconn && st.st == MC_CW1) |=> $stable(link_addr))
		else $error("first control word changed the address");
	a_second_addr: assert property (@(posedge clk) disable iff (rst)
		(ow && !fn && !st.unconn && st.st == MC_CW2 && (st.conn == 3'd0 || ext_ok))
		|=> link_addr == $past(ch_wdata[7:0]))
		else $error("second control word not taken as address");
	a_byte_wrap: assert property (@(posedge clk) disable iff (rst)
		(iw && st.st == MC_DATA && st.op == OP_READ && st.bytei == 3'd7 && !st.unconn &&
		(st.conn == 3'd0 || ext_ok)) |=> link_byte == 3'd0 && ch_rvalid)
		else $error("byte index did not wrap from 7 to 0");
	a_err_clear: assert property (@(posedge clk) disable iff (rst)
		fn |=> !err_flag)
		else $error("function word did not clear error flag");
endmodule
`default_nettype wire

// File: mc_elem_model.sv
// Behavioural model of the external elements on the radial links.
// Assumes mc_chan drives its link outputs from registers on clk.
`timescale 1ns/1ps
`default_nettype none
module mc_elem_model (
	input  wire logic            clk,    // System clock
	input  wire logic [6:1]      sel,    // Element selects
	input  wire logic [2:0]      bidx,   // Byte index
	input  wire logic            wr,     // Byte write pulse
	input  wire logic [7:0]      wdata,  // Byte write data
	output logic      [6:1][7:0] rdata   // Byte from each element
);
	logic [7:0] mem [1:6][0:7];          // One register image per element
	logic       tog = 1'b0;              // Idle pattern toggle
	// Each element stores bytes only on its own link
	always @(posedge clk) begin
		tog <= ~tog;
		for (int i = 1; i < 7; i++)
			// The byte index has already advanced while the write pulse stands
			if (wr && sel[i]) mem[i][bidx - 3'd1] <= wdata;
	end
	// Unselected links show a changing pattern, never a stale byte
	always_comb begin
		for (int i = 1; i < 7; i++)
			rdata[i] = sel[i] ? mem[i][bidx] : {8{tog}};
	end
endmodule
`default_nettype wire

// File: tb_mc_chan.sv
// Self-checking bench for mc_chan; reads are checked by a watcher process.
// Assumes elements 1 to 3 present and 4 to 6 absent; element 3 is pulled mid-run.
`timescale 1ns/1ps
`default_nettype none
module tb_mc_chan;
	import mc_pkg::*;
	logic            clk = 1'b0, rst = 1'b1;        // Clock and reset
	logic            fs = 1'b0, os = 1'b0, is = 1'b0; // Channel strobes
	logic            bev = 1'b0;                    // Board error event
	logic [6:1]      pres = 6'b000111;              // Element presence levels
	logic [4:0]      ch_num = 5'h0e;                // Addressed channel
	logic [11:0]     ch_wdata = 12'h0, ch_rdata;    // Channel words
	logic            ch_rvalid, err_flag, unconnected, link_func, link_wr, board_led;
	logic [6:1]      link_sel;                      // Element selects
	logic [3:0]      link_opcode, link_type;        // Forwarded fields
	logic [7:0]      link_addr, link_wdata, a;      // Address and bytes
	logic [2:0]      link_byte;                     // Byte index
	logic [6:1][7:0] link_rdata;                    // Element read bytes
	logic [7:0]      q[$];                          // Expected read bytes
	logic [31:0]     rs = 32'd25;                   // Random state
	logic [63:0]     v;                             // Register image
	int              errors = 0, checks = 0;        // Counters
	always #2.5 clk = ~clk;
	mc_chan u_dut (.clk(clk), .rst(rst), .ch_num(ch_num), .fn_strobe(fs), .out_strobe(os),
		.in_strobe(is), .ch_wdata(ch_wdata), .ch_rdata(ch_rdata), .ch_rvalid(ch_rvalid),
		.err_flag(err_flag), .unconnected(unconnected), .link_sel(link_sel),
		.link_func(link_func), .link_opcode(link_opcode), .link_type(link_type),
		.link_addr(link_addr), .link_byte(link_byte), .link_wr(link_wr),
		.link_wdata(link_wdata), .link_rdata(link_rdata), .link_present(pres),
		.fault_evt(2'b00), .board_err_evt(bev), .board_led(board_led));
	mc_elem_model u_elem (.clk(clk), .sel(link_sel), .bidx(link_byte), .wr(link_wr),
		.wdata(link_wdata), .rdata(link_rdata));
	// Xorshift source for data bytes
	function logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic chk(input logic [11:0] s, input logic [11:0] e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// One strobe: 0 function, 1 output word, 2 input request
	task automatic st(input int k, input logic [11:0] w);
		@(posedge clk);
		fs <= (k == 0);
		os <= (k == 1);
		is <= (k == 2);
		ch_wdata <= w;
		@(posedge clk);
		fs <= 1'b0;
		os <= 1'b0;
		is <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] e);
		q.push_back(e);
		st(2, 12'h0);
	endtask
	// Function word then two control words, junk in the unused bits
	task automatic op(input logic [11:0] f, input logic [7:0] ad);
		st(0, f);
		st(1, 12'(xs()));
		#1 chk(err_flag, 12'h0);
		st(1, {4'(xs()), ad});
		#1 chk(err_flag, 12'h0);
	endtask
	task automatic wr8(input logic [11:0] f, input logic [7:0] ad, input logic [63:0] d);
		op(f, ad);
		for (int i = 0; i < 8; i++) st(1, {4'h0, d[63-8*((f[2:0]+i)%8) -: 8]});
		#1 chk(err_flag, 12'h0);
	endtask
	task automatic rd8(input logic [11:0] f, input logic [7:0] ad, input logic [63:0] d,
		input logic [2:0] s);
		op(f, ad);
		for (int i = 0; i < 8; i++) rd(d[63-8*((s+i)%8) -: 8]);
		#1 chk(err_flag, 12'h0);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Watcher takes the oldest note whenever a read word appears
	always @(posedge clk) begin
		if (ch_rvalid === 1'b1) begin
			if (q.size() == 0) chk(12'hfff, 12'h0);
			else chk(ch_rdata, {4'h0, q.pop_front()});
		end
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		st(0, 12'h050);
		#1 chk(unconnected, 12'h1);
		@(posedge clk) ch_num <= MC_CHANNEL;
		v = {xs(), xs()} | 64'h1;
		wr8(12'h050, ADR_FAULT1, v);
		rd8(12'h043, ADR_FAULT1, v, 3);
		wr8(12'h050, ADR_ELEM_ID, ~ELEM_ID_VAL);
		rd8(12'h045, ADR_ELEM_ID, ELEM_ID_VAL, 0);
		rd8(12'h040, 8'h55, 64'h0, 0);
		st(0, 12'h0c0);
		rd(8'h01);
		@(posedge clk) bev <= 1'b1;
		@(posedge clk) bev <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(board_led, 12'h1);
		st(0, 12'h0c0);
		rd(8'h05);
		st(0, 12'h030);
		#1 chk(board_led, 12'h0);
		st(0, 12'h070);
		rd8(12'h040, ADR_FAULT1, 64'h0, 0);
		wr8(12'h050, ADR_FMASK, v);
		st(0, 12'h060);
		rd8(12'h040, ADR_FMASK, 64'h0, 0);
		a = 8'(xs());
		op(12'h080, a);
		rd(a);
		rd(a);
		wr8(12'h250, 8'h20, v);
		#1 chk(link_sel, 12'h002);
		chk(link_addr, 12'h020);
		rd8(12'h240, 8'h20, v, 0);
		st(0, 12'h200);
		#1 chk(link_opcode, OP_HALT);
		st(0, 12'h210);
		#1 chk(link_opcode, OP_START);
		@(posedge clk) pres <= 6'b000011;
		st(0, 12'h26a);
		#1 chk(link_type, TYPE_CM_REG);
		chk(link_func, 12'h1);
		st(0, 12'h340);
		st(1, 12'h0);
		#1 chk(err_flag, 12'h1);
		st(0, 12'h240);
		#1 chk(err_flag, 12'h0);
		op(12'h240, 8'h20);
		rd(v[63:56]);
		st(0, 12'hc40);
		#1 chk(unconnected, 12'h1);
		rd(8'h00);
		for (int i = 0; i < 100 && q.size() != 0; i++) @(posedge clk);
		if (q.size() != 0) errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
